// [src/bitop_decode_cfg.svh]
`ifndef BITOP_DECODE_CFG_SVH
`define BITOP_DECODE_CFG_SVH

// ----------------------------------------
// Opcode high nibbles
// ----------------------------------------
`define HI_BIT_BRANCH 4'h0
`define HI_BIT_WRITE 4'h1
`define HI_RMW_DIRECT 4'h3
`define HI_RMW_ACC 4'h4
`define HI_RMW_INDEX 4'h5
`define HI_RMW_IX_OFS 4'h6
`define HI_RMW_IX 4'h7
`define HI_CTL_LOW 4'h8
`define HI_CTL_HIGH 4'h9

// ----------------------------------------
// Read/modify/write low nibbles
// ----------------------------------------
`define LO_NEGATE 4'h0
`define LO_MULTIPLY 4'h2
`define LO_COMPLEMENT 4'h3
`define LO_SHIFT_RIGHT 4'h4
`define LO_ROT_RIGHT 4'h6
`define LO_ARITH_RIGHT 4'h7
`define LO_SHIFT_LEFT 4'h8
`define LO_ROT_LEFT 4'h9
`define LO_DECREMENT 4'ha
`define LO_INCREMENT 4'hc
`define LO_TEST_NZ 4'hd
`define LO_ZERO_OPND 4'hf

// ----------------------------------------
// Control opcodes
// ----------------------------------------
`define OPC_TRAP_RETURN 8'h80
`define OPC_SUB_RETURN 8'h81
`define OPC_SOFT_TRAP 8'h83
`define OPC_HALT 8'h8e
`define OPC_IDLE_WAIT 8'h8f
`define OPC_ACC_TO_IDX 8'h97
`define OPC_CARRY_ZERO 8'h98
`define OPC_CARRY_ONE 8'h99
`define OPC_UNMASK 8'h9a
`define OPC_MASK 8'h9b
`define OPC_STACK_INIT 8'h9c
`define OPC_NO_OP 8'h9d
`define OPC_IDX_TO_ACC 8'h9f

// ----------------------------------------
// Lengths in bytes
// ----------------------------------------
`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3

// ----------------------------------------
// Execution cycles
// ----------------------------------------
`define CYC_BIT_BRANCH 4'h5
`define CYC_BIT_WRITE 4'h5
`define CYC_RMW_REG 4'h3
`define CYC_RMW_MEM 4'h5
`define CYC_RMW_IX_OFS 4'h6
`define CYC_TEST_MEM 4'h4
`define CYC_TEST_IX_OFS 4'h5
`define CYC_MULTIPLY 4'hb
`define CYC_SOFT_TRAP 4'ha
`define CYC_TRAP_RETURN 4'h9
`define CYC_SUB_RETURN 4'h6
`define CYC_INHERENT 4'h2

`endif

// [src/bitop_decode_pkg.sv]
package bitop_decode_pkg;

  typedef enum logic [2:0] {
    grp_none = 3'h0,
    grp_bit_branch = 3'h1,
    grp_bit_write = 3'h2,
    grp_rmw = 3'h3,
    grp_control = 3'h4
  } group_t;

  typedef enum logic [2:0] {
    mode_inherent_acc = 3'h0,
    mode_inherent_idx = 3'h1,
    mode_direct = 3'h2,
    mode_indexed = 3'h3,
    mode_indexed_ofs = 3'h4,
    mode_inherent = 3'h5
  } addr_mode_t;

  typedef enum logic [4:0] {
    op_none = 5'h00,
    op_branch_on_bit_high = 5'h01,
    op_branch_on_bit_low = 5'h02,
    op_bit_force_one = 5'h03,
    op_bit_force_zero = 5'h04,
    op_negate = 5'h05,
    op_complement = 5'h06,
    op_shift_right = 5'h07,
    op_rotate_right_carry = 5'h08,
    op_arith_right = 5'h09,
    op_shift_left = 5'h0a,
    op_rotate_left_carry = 5'h0b,
    op_decrement = 5'h0c,
    op_increment = 5'h0d,
    op_test_negative_zero = 5'h0e,
    op_zero_operand = 5'h0f,
    op_multiply_op = 5'h10,
    op_return_from_trap = 5'h11,
    op_return_from_sub = 5'h12,
    op_software_trap = 5'h13,
    op_halt = 5'h14,
    op_idle_wait = 5'h15,
    op_acc_to_idx = 5'h16,
    op_idx_to_acc = 5'h17,
    op_carry_flag_zero = 5'h18,
    op_carry_flag_one = 5'h19,
    op_unmask_interrupts = 5'h1a,
    op_mask_interrupts = 5'h1b,
    op_stack_init = 5'h1c,
    op_no_op = 5'h1d
  } op_t;

  // Action on one condition flag at the end of the instruction
  typedef enum logic [2:0] {
    fa_keep = 3'h0,
    fa_zero = 3'h1,
    fa_one = 3'h2,
    fa_result = 3'h3,
    fa_stack = 3'h4
  } flag_act_t;

  typedef enum logic {
    seq_idle = 1'b0,
    seq_run = 1'b1
  } seq_state_t;

  // One decoded instruction as the decoder registers it
  typedef struct packed {
    group_t grp;
    op_t op;
    addr_mode_t mode;
    logic [1:0] len;
    logic [3:0] cyc;
    logic wb;
    logic unk;
    flag_act_t h;
    flag_act_t i;
    flag_act_t n;
    flag_act_t z;
    flag_act_t c;
  } dec_t;

endpackage : bitop_decode_pkg

// [src/cycle_sequencer.sv]
`timescale 1ns/1ps
`include "bitop_decode_cfg.svh"

module cycle_sequencer
  import bitop_decode_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Start of an instruction
  input wire logic start,
  input wire logic [3:0] cycles,
  // Progress
  output logic busy,
  output logic last
);

  seq_state_t state_reg;
  seq_state_t state_next;
  logic [3:0] count_reg;
  logic [3:0] count_next;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      seq_idle: begin
        if (start) begin
          state_next = seq_run;
          count_next = cycles;
        end
      end
      seq_run: begin
        if (count_reg == 4'h1) begin
          // Back-to-back start in the last cycle keeps running
          if (start) begin
            count_next = cycles;
          end else begin
            state_next = seq_idle;
            count_next = 4'h0;
          end
        end else begin
          count_next = count_reg - 4'h1;
        end
      end
      default: begin
        state_next = seq_idle;
        count_next = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= seq_idle;
      count_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  assign busy = (state_reg == seq_run);
  assign last = busy && (count_reg == 4'h1);

endmodule : cycle_sequencer

// [src/bitop_rmw_decoder.sv]
`timescale 1ns/1ps
`include "bitop_decode_cfg.svh"

// Functional notes
// - Opcode 2*n is branch-on-bit-high for bit n, three bytes, five cycles.
// - Opcode 0x01+2*n is branch-on-bit-low for bit n, three bytes, five cycles.
// - Opcodes 0x10+2*n and 0x11+2*n force bit n of a direct byte to one or zero, two bytes, five cycles.
// - Rotate-left-carry uses 49, 59, 39, 79, 69 with 3, 3, 5, 5 and 6 cycles.
// - Rotate-right-carry uses 46, 56, 36, 76, 66 with the usual read/modify/write cycle counts.
// - Test-negative-zero uses 4D, 5D, 3D, 7D, 6D and its memory forms take 4, 4 and 5 cycles.
// - Opcode 9B sets the interrupt mask, one byte, two cycles, other flags kept.
// - Opcode 9A clears the interrupt mask, one byte, two cycles, other flags kept.
// - Software trap 83 takes 10 cycles, trap return 80 takes 9, subroutine return 81 takes 6, all one byte.
// - The read/modify/write high nibble picks the mode: 4 acc, 5 index, 3 direct, 7 indexed, 6 indexed with offset; offset forms are two bytes.
// - Zero-operand forces N to 0 and Z to 1, carry-zero forces C to 0, and multiply (42) takes 11 cycles.
module bitop_rmw_decoder
  import bitop_decode_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Opcode from the fetch unit
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  output logic opcode_ready,
  // Decoded instruction
  output logic dec_valid,
  output group_t dec_group,
  output op_t dec_op,
  output addr_mode_t dec_mode,
  output logic [2:0] dec_bit,
  output logic [1:0] dec_len,
  output logic [3:0] dec_cycles,
  output logic dec_writes_back,
  output logic dec_unknown,
  // Condition flag actions
  output flag_act_t act_half,
  output flag_act_t act_mask,
  output flag_act_t act_neg,
  output flag_act_t act_zero,
  output flag_act_t act_carry,
  // Sequencing
  output logic exec_busy,
  output logic exec_last
);

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function automatic dec_t blank_dec();
    return '{grp: grp_none, op: op_none, mode: mode_inherent,
      len: `LEN_ONE, cyc: `CYC_INHERENT, wb: 1'b0, unk: 1'b1,
      h: fa_keep, i: fa_keep, n: fa_keep, z: fa_keep, c: fa_keep};
  endfunction : blank_dec

  function automatic dec_t decode_rmw(input logic [7:0] opc);
    dec_t d;
    d = blank_dec();
    d.grp = grp_rmw;
    d.unk = 1'b0;
    d.wb = 1'b1;
    d.n = fa_result;
    d.z = fa_result;
    d.c = fa_result;
    case (opc[7:4])
      `HI_RMW_ACC: d.mode = mode_inherent_acc;
      `HI_RMW_INDEX: d.mode = mode_inherent_idx;
      `HI_RMW_DIRECT: d.mode = mode_direct;
      `HI_RMW_IX: d.mode = mode_indexed;
      default: d.mode = mode_indexed_ofs;
    endcase
    // Operand byte on the direct and offset forms only
    if (d.mode == mode_direct || d.mode == mode_indexed_ofs) begin
      d.len = `LEN_TWO;
    end
    if (d.mode == mode_indexed_ofs) begin
      d.cyc = `CYC_RMW_IX_OFS;
    end else if (d.mode == mode_direct || d.mode == mode_indexed) begin
      d.cyc = `CYC_RMW_MEM;
    end else begin
      d.cyc = `CYC_RMW_REG;
    end
    case (opc[3:0])
      `LO_NEGATE: d.op = op_negate;
      `LO_COMPLEMENT: begin
        d.op = op_complement;
        d.c = fa_one;
      end
      `LO_SHIFT_RIGHT: begin
        d.op = op_shift_right;
        d.n = fa_zero;
      end
      `LO_ROT_RIGHT: d.op = op_rotate_right_carry;
      `LO_ARITH_RIGHT: d.op = op_arith_right;
      `LO_SHIFT_LEFT: d.op = op_shift_left;
      `LO_ROT_LEFT: d.op = op_rotate_left_carry;
      `LO_DECREMENT: begin
        d.op = op_decrement;
        d.c = fa_keep;
      end
      `LO_INCREMENT: begin
        d.op = op_increment;
        d.c = fa_keep;
      end
      `LO_TEST_NZ: begin
        // No write back, so memory forms lose one cycle
        d.op = op_test_negative_zero;
        d.wb = 1'b0;
        d.c = fa_keep;
        if (d.mode == mode_direct || d.mode == mode_indexed) begin
          d.cyc = `CYC_TEST_MEM;
        end else if (d.mode == mode_indexed_ofs) begin
          d.cyc = `CYC_TEST_IX_OFS;
        end
      end
      `LO_ZERO_OPND: begin
        d.op = op_zero_operand;
        d.n = fa_zero;
        d.z = fa_one;
        d.c = fa_keep;
      end
      `LO_MULTIPLY: begin
        // Only the accumulator column holds multiply
        if (opc[7:4] == `HI_RMW_ACC) begin
          d.op = op_multiply_op;
          d.wb = 1'b0;
          d.mode = mode_inherent;
          d.cyc = `CYC_MULTIPLY;
          d.h = fa_zero;
          d.n = fa_keep;
          d.z = fa_keep;
          d.c = fa_zero;
        end else begin
          d = blank_dec();
        end
      end
      default: d = blank_dec();
    endcase
    return d;
  endfunction : decode_rmw

  function automatic dec_t decode_control(input logic [7:0] opc);
    dec_t d;
    d = blank_dec();
    d.grp = grp_control;
    d.unk = 1'b0;
    case (opc)
      `OPC_TRAP_RETURN: begin
        d.op = op_return_from_trap;
        d.cyc = `CYC_TRAP_RETURN;
        d.h = fa_stack;
        d.i = fa_stack;
        d.n = fa_stack;
        d.z = fa_stack;
        d.c = fa_stack;
      end
      `OPC_SUB_RETURN: begin
        d.op = op_return_from_sub;
        d.cyc = `CYC_SUB_RETURN;
      end
      `OPC_SOFT_TRAP: begin
        d.op = op_software_trap;
        d.cyc = `CYC_SOFT_TRAP;
        d.i = fa_one;
      end
      `OPC_HALT: begin
        d.op = op_halt;
        d.i = fa_zero;
      end
      `OPC_IDLE_WAIT: begin
        d.op = op_idle_wait;
        d.i = fa_zero;
      end
      `OPC_ACC_TO_IDX: d.op = op_acc_to_idx;
      `OPC_IDX_TO_ACC: d.op = op_idx_to_acc;
      `OPC_CARRY_ZERO: begin
        d.op = op_carry_flag_zero;
        d.c = fa_zero;
      end
      `OPC_CARRY_ONE: begin
        d.op = op_carry_flag_one;
        d.c = fa_one;
      end
      `OPC_UNMASK: begin
        d.op = op_unmask_interrupts;
        d.i = fa_zero;
      end
      `OPC_MASK: begin
        d.op = op_mask_interrupts;
        d.i = fa_one;
      end
      `OPC_STACK_INIT: d.op = op_stack_init;
      `OPC_NO_OP: d.op = op_no_op;
      default: d = blank_dec();
    endcase
    return d;
  endfunction : decode_control

  function automatic dec_t decode_opcode(input logic [7:0] opc);
    dec_t d;
    d = blank_dec();
    case (opc[7:4])
      `HI_BIT_BRANCH: begin
        d.grp = grp_bit_branch;
        d.unk = 1'b0;
        d.op = opc[0] ? op_branch_on_bit_low : op_branch_on_bit_high;
        d.mode = mode_direct;
        d.len = `LEN_THREE;
        d.cyc = `CYC_BIT_BRANCH;
        d.c = fa_result;
      end
      `HI_BIT_WRITE: begin
        d.grp = grp_bit_write;
        d.unk = 1'b0;
        d.op = opc[0] ? op_bit_force_zero : op_bit_force_one;
        d.mode = mode_direct;
        d.len = `LEN_TWO;
        d.cyc = `CYC_BIT_WRITE;
        d.wb = 1'b1;
      end
      `HI_RMW_DIRECT, `HI_RMW_ACC, `HI_RMW_INDEX, `HI_RMW_IX_OFS,
      `HI_RMW_IX: d = decode_rmw(opc);
      `HI_CTL_LOW, `HI_CTL_HIGH: d = decode_control(opc);
      default: d = blank_dec();
    endcase
    return d;
  endfunction : decode_opcode

  // ----------------------------------------
  // Decode register
  // ----------------------------------------
  dec_t dec_reg;
  dec_t dec_next;
  dec_t fresh_dec;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic valid_reg;
  logic valid_next;
  logic take;
  logic seq_busy;
  logic seq_last;

  // New opcode accepted when idle or in the final cycle
  assign opcode_ready = !seq_busy || seq_last;
  assign take = opcode_valid && opcode_ready;
  assign fresh_dec = decode_opcode(opcode);

  always_comb begin
    dec_next = dec_reg;
    bit_next = bit_reg;
    valid_next = 1'b0;
    if (take) begin
      dec_next = fresh_dec;
      bit_next = opcode[3:1];
      valid_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dec_reg <= blank_dec();
      bit_reg <= 3'h0;
      valid_reg <= 1'b0;
    end else begin
      dec_reg <= dec_next;
      bit_reg <= bit_next;
      valid_reg <= valid_next;
    end
  end

  cycle_sequencer u_seq (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(take),
    .cycles(fresh_dec.cyc),
    .busy(seq_busy),
    .last(seq_last)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dec_valid = valid_reg;
  assign dec_group = dec_reg.grp;
  assign dec_op = dec_reg.op;
  assign dec_mode = dec_reg.mode;
  assign dec_bit = bit_reg;
  assign dec_len = dec_reg.len;
  assign dec_cycles = dec_reg.cyc;
  assign dec_writes_back = dec_reg.wb;
  assign dec_unknown = dec_reg.unk;
  assign act_half = dec_reg.h;
  assign act_mask = dec_reg.i;
  assign act_neg = dec_reg.n;
  assign act_zero = dec_reg.z;
  assign act_carry = dec_reg.c;
  assign exec_busy = seq_busy;
  assign exec_last = seq_last;

endmodule : bitop_rmw_decoder

// [test/decode_checker_sva.sv]
`timescale 1ns/1ps
module decode_checker
  import bitop_decode_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Opcode side
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  input wire logic opcode_ready,
  // Decoded side
  input wire op_t dec_op,
  input wire addr_mode_t dec_mode,
  input wire logic [2:0] dec_bit,
  input wire logic [1:0] dec_len,
  input wire logic [3:0] dec_cycles,
  input wire flag_act_t act_half,
  input wire flag_act_t act_mask,
  input wire flag_act_t act_neg,
  input wire flag_act_t act_zero,
  input wire flag_act_t act_carry,
  input wire logic exec_busy,
  input wire logic exec_last
);
  logic take;
  logic [2:0] nbit;
  logic lsb;
  logic hnz;
  assign take = opcode_valid && opcode_ready;
  assign nbit = opcode[3:1];
  assign lsb = opcode[0];
  assign hnz = act_half == fa_keep && act_neg == fa_keep && act_zero == fa_keep;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  AST_BRANCH_HIGH:
  assert property (take && opcode[7:4] == 4'h0 && !lsb |=> dec_op ==
    op_branch_on_bit_high && dec_bit == $past(nbit) && dec_len == 2'h3)
    else $error("bit set branch decoded wrongly");
  AST_BRANCH_LOW:
  assert property (take && opcode[7:4] == 4'h0 && lsb |=> dec_op ==
    op_branch_on_bit_low && dec_bit == $past(nbit) && dec_cycles == 4'h5)
    else $error("bit clear branch decoded wrongly");
  AST_BIT_WRITE:
  assert property (take && opcode[7:4] == 4'h1 |=> dec_len == 2'h2 &&
    dec_cycles == 4'h5 && ($past(lsb) ? dec_op == op_bit_force_zero :
    dec_op == op_bit_force_one))
    else $error("bit write decoded wrongly");
  AST_ROT_LEFT:
  assert property (take && opcode == 8'h69 |=> dec_op == op_rotate_left_carry
    ##1 exec_busy[*4] ##1 exec_last)
    else $error("rotate left offset form timing wrong");
  AST_TEST_MEM:
  assert property (take && opcode inside {8'h3d, 8'h7d} |=> dec_cycles == 4'h4)
    else $error("test memory form cycles wrong");
  AST_MASK_SET:
  assert property (take && opcode == 8'h9b |=> act_mask == fa_one && hnz &&
    act_carry == fa_keep ##1 exec_last)
    else $error("mask set decoded wrongly");
  AST_MASK_CLR:
  assert property (take && opcode == 8'h9a |=> act_mask == fa_zero && hnz &&
    act_carry == fa_keep && dec_len == 2'h1)
    else $error("mask clear decoded wrongly");
  AST_TRAP_RET:
  assert property (take && opcode == 8'h80 |=> (exec_busy && !exec_last)[*8]
    ##1 exec_last)
    else $error("trap return length wrong");
  AST_OFS_MODE:
  assert property (take && opcode inside {8'h69, 8'h66, 8'h6d, 8'h6f} |=>
    dec_mode == mode_indexed_ofs && dec_len == 2'h2)
    else $error("offset form decoded wrongly");
  AST_ZERO_OP:
  assert property (take && opcode[3:0] == 4'hf && opcode[7:4] inside {[3:7]}
    |=> act_neg == fa_zero && act_zero == fa_one)
    else $error("zero operand flags wrong");
  AST_BTB_CARRY:
  assert property (take && opcode[7:4] == 4'h0 |=> act_carry == fa_result &&
    hnz && act_mask == fa_keep)
    else $error("bit branch flags wrong");
endmodule : decode_checker

// [test/opcode_feeder.sv]
`timescale 1ns/1ps
module opcode_feeder (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Bench request
  input wire logic send,
  input wire logic [7:0] byte_in,
  // Decoder side
  input wire logic opcode_ready,
  output logic opcode_valid,
  output logic [7:0] opcode
);
  initial begin
    opcode_valid = 1'b0;
    opcode = 8'h00;
  end
  // Released byte is inverted so a stale opcode cannot pass
  always @(posedge clk_sys) begin
    if (reset) begin
      opcode_valid <= 1'b0;
    end else begin
      if (opcode_valid && opcode_ready) begin
        opcode_valid <= 1'b0;
        opcode <= ~opcode;
      end
      if (send) begin
        opcode_valid <= 1'b1;
        opcode <= byte_in;
      end
    end
  end
endmodule : opcode_feeder

// [test/cpu_bitop_rmw_control_decode_tb.sv]
`timescale 1ns/1ps
module cpu_bitop_rmw_control_decode_tb;
  import bitop_decode_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic send = 1'b0;
  logic [7:0] byte_in = 8'h00;
  logic opcode_valid, opcode_ready, dec_valid, dec_writes_back, dec_unknown;
  logic [7:0] opcode;
  group_t dec_group;
  op_t dec_op;
  addr_mode_t dec_mode;
  logic [2:0] dec_bit;
  logic [1:0] dec_len;
  logic [3:0] dec_cycles;
  flag_act_t act_half, act_mask, act_neg, act_zero, act_carry;
  logic exec_busy, exec_last;
  logic hnz_kept;
  assign hnz_kept = act_half == fa_keep && act_neg == fa_keep &&
    act_zero == fa_keep;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [3:0] hi [5] = '{4'h4, 4'h5, 4'h3, 4'h7, 4'h6};
  addr_mode_t md [5] = '{mode_inherent_acc, mode_inherent_idx, mode_direct,
    mode_indexed, mode_indexed_ofs};
  logic [1:0] ln [5] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h2};
  logic [3:0] cy [5] = '{4'h3, 4'h3, 4'h5, 4'h5, 4'h6};
  logic [3:0] ty [5] = '{4'h3, 4'h3, 4'h4, 4'h4, 4'h5};

  always #2.5 clk_sys = ~clk_sys;

  opcode_feeder feeder (.clk_sys, .reset, .send, .byte_in, .opcode_ready,
    .opcode_valid, .opcode);

  bitop_rmw_decoder dut (.clk_sys, .reset, .opcode_valid, .opcode,
    .opcode_ready, .dec_valid, .dec_group, .dec_op, .dec_mode, .dec_bit,
    .dec_len, .dec_cycles, .dec_writes_back, .dec_unknown, .act_half,
    .act_mask, .act_neg, .act_zero, .act_carry, .exec_busy, .exec_last);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [7:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic offer(input logic [7:0] op);
    @(negedge clk_sys);
    send = 1'b1;
    byte_in = op;
    @(negedge clk_sys);
    send = 1'b0;
  endtask : offer

  task automatic wait_dec(output int gap);
    gap = 0;
    while (dec_valid !== 1'b1 && gap < 40) begin
      @(negedge clk_sys);
      gap++;
    end
  endtask : wait_dec

  task automatic decode(input logic [7:0] op, input op_t opx,
    input logic [1:0] len, input logic [3:0] cyc);
    int gap;
    int busy;
    int lasts;
    offer(op);
    wait_dec(gap);
    chk("valid", 8'h01, 8'(dec_valid));
    chk("op", 8'(opx), 8'(dec_op));
    chk("len", 8'(len), 8'(dec_len));
    chk("cycles", 8'(cyc), 8'(dec_cycles));
    chk("unknown", 8'(opx == op_none), 8'(dec_unknown));
    busy = 0;
    lasts = 0;
    while (exec_busy === 1'b1 && busy < 20) begin
      // Ready only in the final cycle of the instruction
      chk("ready", 8'(busy + 1 == cyc), 8'(opcode_ready));
      if (exec_last === 1'b1) begin
        lasts++;
        chk("last at", 8'(cyc), 8'(busy + 1));
      end
      busy++;
      @(negedge clk_sys);
      if (busy == 1) chk("valid pulse", 8'h00, 8'(dec_valid));
    end
    chk("busy cycles", 8'(cyc), 8'(busy));
    chk("last count", 8'h01, 8'(lasts));
  endtask : decode

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    chk("ready", 8'h01, 8'(opcode_ready));
    chk("busy", 8'h00, 8'(exec_busy));
    chk("op", 8'(op_none), 8'(dec_op));
    $display("test reset done");
  endtask : test_reset

  task automatic test_bits();
    for (int n = 0; n < 8; n++) begin
      decode(8'(2 * n), op_branch_on_bit_high, 2'h3, 4'h5);
      chk("bit", 8'(n), 8'(dec_bit));
      chk("group", 8'(grp_bit_branch), 8'(dec_group));
      chk("carry", 8'(fa_result), 8'(act_carry));
      chk("kept", 8'h01, 8'(hnz_kept && act_mask == fa_keep));
      decode(8'(2 * n + 1), op_branch_on_bit_low, 2'h3, 4'h5);
      chk("bit", 8'(n), 8'(dec_bit));
      chk("carry", 8'(fa_result), 8'(act_carry));
      decode(8'h10 + 8'(2*n), op_bit_force_one, 2'h2, 4'h5);
      chk("bit", 8'(n), 8'(dec_bit));
      decode(8'h11 + 8'(2*n), op_bit_force_zero, 2'h2, 4'h5);
      chk("bit", 8'(n), 8'(dec_bit));
      chk("group", 8'(grp_bit_write), 8'(dec_group));
      chk("wb", 8'h01, 8'(dec_writes_back));
    end
    $display("test bits done");
  endtask : test_bits

  task automatic test_rmw();
    for (int i = 0; i < 5; i++) begin
      decode({hi[i],4'h9}, op_rotate_left_carry, ln[i], cy[i]);
      chk("mode", 8'(md[i]), 8'(dec_mode));
      chk("wb", 8'h01, 8'(dec_writes_back));
      decode({hi[i],4'h6}, op_rotate_right_carry, ln[i], cy[i]);
      chk("mode", 8'(md[i]), 8'(dec_mode));
      decode({hi[i],4'hd}, op_test_negative_zero, ln[i], ty[i]);
      chk("wb", 8'h00, 8'(dec_writes_back));
      decode({hi[i],4'hf}, op_zero_operand, ln[i], cy[i]);
      chk("neg", 8'(fa_zero), 8'(act_neg));
      chk("zero", 8'(fa_one), 8'(act_zero));
    end
    $display("test rmw done");
  endtask : test_rmw

  task automatic test_control();
    decode(8'h9b, op_mask_interrupts, 2'h1, 4'h2);
    chk("mask", 8'(fa_one), 8'(act_mask));
    chk("kept", 8'h01, 8'(hnz_kept && act_carry == fa_keep));
    chk("group", 8'(grp_control), 8'(dec_group));
    decode(8'h9a, op_unmask_interrupts, 2'h1, 4'h2);
    chk("mask", 8'(fa_zero), 8'(act_mask));
    chk("kept", 8'h01, 8'(hnz_kept && act_carry == fa_keep));
    decode(8'h83, op_software_trap, 2'h1, 4'ha);
    decode(8'h80, op_return_from_trap, 2'h1, 4'h9);
    decode(8'h81, op_return_from_sub, 2'h1, 4'h6);
    decode(8'h42, op_multiply_op, 2'h1, 4'hb);
    decode(8'h98, op_carry_flag_zero, 2'h1, 4'h2);
    chk("carry", 8'(fa_zero), 8'(act_carry));
    // Holes in the read/modify/write columns come back as unknown
    decode(8'h41, op_none, 2'h1, 4'h2);
    decode(8'h5e, op_none, 2'h1, 4'h2);
    chk("group", 8'(grp_none), 8'(dec_group));
    $display("test control done");
  endtask : test_control

  // Second opcode waits while busy; 2 of the 5 cycles pass in offer
  task automatic test_order();
    int gap;
    offer(8'h39);
    wait_dec(gap);
    offer(8'h9b);
    wait_dec(gap);
    chk("spacing", 8'h03, 8'(gap));
    chk("op", 8'(op_mask_interrupts), 8'(dec_op));
    $display("test order done");
  endtask : test_order

  // Reset in mid-instruction drops the sequencer and the decode
  task automatic test_midreset();
    int gap;
    offer(8'h80);
    wait_dec(gap);
    @(negedge clk_sys);
    reset = 1'b1;
    @(negedge clk_sys);
    reset = 1'b0;
    chk("busy", 8'h00, 8'(exec_busy));
    chk("ready", 8'h01, 8'(opcode_ready));
    chk("op", 8'(op_none), 8'(dec_op));
    decode(8'h81, op_return_from_sub, 2'h1, 4'h6);
    $display("test midreset done");
  endtask : test_midreset

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      results();
    end
  end

  initial begin
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
    test_reset();
    test_bits();
    test_rmw();
    test_control();
    test_order();
    test_midreset();
    results();
  end
endmodule : cpu_bitop_rmw_control_decode_tb

bind bitop_rmw_decoder decode_checker chk (.clk_sys, .reset, .opcode_valid,
  .opcode, .opcode_ready, .dec_op, .dec_mode, .dec_bit, .dec_len,
  .dec_cycles, .act_half, .act_mask, .act_neg, .act_zero, .act_carry,
  .exec_busy, .exec_last);
